/* File: host_pin_map.svh */
// Constants for the host and memory pin interface
`ifndef HOST_PIN_MAP_SVH
`define HOST_PIN_MAP_SVH
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_TERM_ADDR 4'h2
`define REG_DMA_ADDR 4'h3
`define REG_DMA_DATA 4'h4
`define REG_DMA_COUNT 4'h5
`define CTL_ROLE_BIT 0
`define CTL_PDP_BIT 1
`define CTL_GO_BIT 2
`define CTL_WRITE_BIT 3
`define CTL_RESET 16'h0000
`define RESET_MIN_NS 500
`define CLK_PERIOD_NS 25
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: host_pin_pkg.sv */
// Types for the host and memory pin interface
package host_pin_pkg;
    typedef enum logic [2:0] {DMA_IDLE, DMA_WAIT, DMA_SETUP, DMA_STROBE, DMA_GAP} dma_state_type;
endpackage

/* File: host_pin_if.sv */
// Host register port, strapped address capture and DMA RAM strobes
`timescale 1ns/10ps
`include "host_pin_map.svh"
module host_pin_if #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o,
    output logic data_oe_o,
    input wire logic [3:0] addr_low_i,
    output logic [WIDTH-1:0] addr_o,
    output logic addr_low_oe_o,
    output logic addr_high_oe_o,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic cs_n_i,
    input wire logic addr_drive_permit_i,
    input wire logic [5:0] term_addr_i,
    input wire logic role_select_pin_i,
    input wire logic lock_i,
    input wire logic external_abort_n_i,
    input wire logic ram_select_in_n_i,
    output logic ram_select_out_n_o,
    output logic ram_read_strobe_n_o,
    output logic ram_write_strobe_n_o,
    input wire logic dma_grant_n_i,
    output logic dma_request_o,
    output logic role_is_controller_o,
    output logic [4:0] term_addr_o,
    output logic term_addr_parity_ok_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage is read only by the second
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] pins;
    assign pins = {master_reset_n_i, rd_n_i, wr_n_i, cs_n_i, addr_drive_permit_i,
                   role_select_pin_i, lock_i, external_abort_n_i, dma_grant_n_i,
                   term_addr_i[5:0]};
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
        end
        else
        begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end
    logic master_reset_n_n_s, rd_n_s, wr_n_s, cs_n_s, permit_s, role_pin_s, lock_s, abort_n_s, grant_n_s;
    logic [4:0] ta_s;
    logic ta_par_s;
    assign {master_reset_n_n_s, rd_n_s, wr_n_s, cs_n_s, permit_s, role_pin_s, lock_s, abort_n_s,
            grant_n_s, ta_par_s, ta_s} = sync2_q;
    // Data and address pass through the same two stages as the strobes, so the
    // host must hold them steady for the whole strobe
    logic [WIDTH-1:0] data_s1_q, data_s_q;
    logic [3:0] al_s1_q, al_s_q;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_s1_q <= '0;
            data_s_q <= '0;
            al_s1_q <= '0;
            al_s_q <= '0;
        end
        else
        begin
            data_s1_q <= data_i;
            data_s_q <= data_s1_q;
            al_s1_q <= addr_low_i;
            al_s_q <= al_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [WIDTH-1:0] ctrl_q, ctrl_d, dma_addr_q, dma_addr_d, dma_data_q, dma_data_d;
    logic [WIDTH-1:0] dma_cnt_q, dma_cnt_d, rdata_q, rdata_d;
    logic [4:0] ta_q, ta_d;
    logic role_q, role_d, wr_seen_q, wr_seen_d, rd_act_q, rd_act_d;
    host_pin_pkg::dma_state_type st_q, st_d;
    logic in_reset, host_wr, done;
    assign in_reset = !master_reset_n_n_s;
    assign host_wr = !wr_n_s && !cs_n_s && !wr_seen_q;

    always_comb
    begin
        ctrl_d = ctrl_q;
        dma_addr_d = dma_addr_q;
        dma_cnt_d = dma_cnt_q;
        ta_d = ta_q;
        role_d = role_q;
        rdata_d = rdata_q;
        wr_seen_d = !wr_n_s && !cs_n_s;
        rd_act_d = !rd_n_s && !cs_n_s;
        // Hardware clear first, so a host write of the go bit in the same cycle wins
        if (done)
        begin
            ctrl_d[`CTL_GO_BIT] = 1'b0;
        end
        if (host_wr)
        begin
            case (al_s_q)
                `REG_CONTROL: ctrl_d = data_s_q;
                `REG_DMA_ADDR: dma_addr_d = data_s_q;
                `REG_DMA_COUNT: dma_cnt_d = data_s_q;
                `REG_TERM_ADDR:
                begin
                    if (!lock_s)
                    begin
                        ta_d = data_s_q[4:0];
                    end
                end
                default: ;
            endcase
        end
        // Strap capture last, so a host write cannot mask it during master reset
        if (in_reset)
        begin
            ta_d = ta_s;
        end
        // While locked, mode is taken from the pin during master reset and held otherwise; unlocked, the control bit sets it
        if (!lock_s)
        begin
            role_d = ctrl_d[`CTL_ROLE_BIT];
        end
        else if (in_reset)
        begin
            role_d = role_pin_s;
        end
        if (!rd_n_s && !cs_n_s)
        begin
            case (al_s_q)
                `REG_CONTROL: rdata_d = ctrl_q;
                `REG_STATUS: rdata_d = {{(WIDTH-4){1'b0}}, lock_s, role_q,
                                        st_q != host_pin_pkg::DMA_IDLE, ^{ta_par_s, ta_s}};
                `REG_TERM_ADDR: rdata_d = {{(WIDTH-5){1'b0}}, ta_q};
                `REG_DMA_ADDR: rdata_d = dma_addr_q;
                `REG_DMA_DATA: rdata_d = dma_data_q;
                `REG_DMA_COUNT: rdata_d = dma_cnt_q;
                default: rdata_d = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA transfer engine: one strobe pulse per word after grant
    logic [WIDTH-1:0] ma_q, ma_d, left_q, left_d;
    always_comb
    begin
        st_d = st_q;
        ma_d = ma_q;
        left_d = left_q;
        dma_data_d = dma_data_q;
        done = 1'b0;
        if (host_wr && al_s_q == `REG_DMA_DATA)
        begin
            dma_data_d = data_s_q;
        end
        case (st_q)
            host_pin_pkg::DMA_IDLE:
            begin
                if (ctrl_q[`CTL_GO_BIT] && dma_cnt_q != '0)
                begin
                    st_d = host_pin_pkg::DMA_WAIT;
                    ma_d = dma_addr_q;
                    left_d = dma_cnt_q;
                end
            end
            host_pin_pkg::DMA_WAIT:
            begin
                if (!grant_n_s)
                begin
                    st_d = host_pin_pkg::DMA_SETUP;
                end
            end
            host_pin_pkg::DMA_SETUP: st_d = host_pin_pkg::DMA_STROBE;
            host_pin_pkg::DMA_STROBE:
            begin
                if (!ctrl_q[`CTL_WRITE_BIT])
                begin
                    dma_data_d = data_s_q;
                end
                st_d = host_pin_pkg::DMA_GAP;
            end
            host_pin_pkg::DMA_GAP:
            begin
                ma_d = ma_q + 16'h0001;
                left_d = left_q - 16'h0001;
                if (left_q == 16'h0001)
                begin
                    st_d = host_pin_pkg::DMA_IDLE;
                    done = 1'b1;
                end
                else
                begin
                    st_d = host_pin_pkg::DMA_SETUP;
                end
            end
            default: st_d = host_pin_pkg::DMA_IDLE;
        endcase
        if (!abort_n_s)
        begin
            st_d = host_pin_pkg::DMA_IDLE;
            done = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `CTL_RESET;
            dma_addr_q <= '0;
            dma_data_q <= '0;
            dma_cnt_q <= '0;
            rdata_q <= '0;
            ta_q <= '0;
            role_q <= 1'b0;
            wr_seen_q <= 1'b0;
            rd_act_q <= 1'b0;
            st_q <= host_pin_pkg::DMA_IDLE;
            ma_q <= '0;
            left_q <= '0;
        end
        else if (in_reset)
        begin
            ctrl_q <= `CTL_RESET;
            dma_addr_q <= '0;
            dma_data_q <= '0;
            dma_cnt_q <= '0;
            rdata_q <= '0;
            ta_q <= ta_d;
            role_q <= role_d;
            wr_seen_q <= 1'b0;
            rd_act_q <= 1'b0;
            st_q <= host_pin_pkg::DMA_IDLE;
            ma_q <= '0;
            left_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            dma_addr_q <= dma_addr_d;
            dma_data_q <= dma_data_d;
            dma_cnt_q <= dma_cnt_d;
            rdata_q <= rdata_d;
            ta_q <= ta_d;
            role_q <= role_d;
            wr_seen_q <= wr_seen_d;
            rd_act_q <= rd_act_d;
            st_q <= st_d;
            ma_q <= ma_d;
            left_q <= left_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins
    logic mem_busy, strobe, pdp;
    assign mem_busy = st_q inside {host_pin_pkg::DMA_SETUP, host_pin_pkg::DMA_STROBE,
                                   host_pin_pkg::DMA_GAP};
    assign strobe = st_q == host_pin_pkg::DMA_STROBE;
    assign pdp = ctrl_q[`CTL_PDP_BIT];
    // Request stands for the whole transfer so the host keeps its grant until the end
    assign dma_request_o = st_q != host_pin_pkg::DMA_IDLE;
    assign addr_o = ma_q;
    assign addr_high_oe_o = mem_busy && permit_s;
    assign addr_low_oe_o = mem_busy && permit_s;
    assign data_o = rd_act_q ? rdata_q : dma_data_q;
    assign data_oe_o = rd_act_q || (mem_busy && ctrl_q[`CTL_WRITE_BIT]);
    // Pass-through is raw so the host's RAM cycle sees no sync delay
    assign ram_select_out_n_o = !(mem_busy || (pdp && !ram_select_in_n_i));
    assign ram_read_strobe_n_o = !(strobe && !ctrl_q[`CTL_WRITE_BIT]);
    assign ram_write_strobe_n_o = !(strobe && ctrl_q[`CTL_WRITE_BIT]);
    assign role_is_controller_o = role_q;
    assign term_addr_o = ta_q;
    assign term_addr_parity_ok_o = ^{ta_par_s, ta_s};

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence granted_s;
        !grant_n_s;
    endsequence
    strobe_after_grant_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(ram_read_strobe_n_o) |-> !$past(grant_n_s, 2))
        else $error("read strobe without grant");
    write_pulse_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ram_write_strobe_n_o |=> ram_write_strobe_n_o)
        else $error("write strobe longer than one cycle");
    addr_permit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !permit_s |-> !addr_high_oe_o && !addr_low_oe_o)
        else $error("address driven without permit");
    abort_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !abort_n_s && !in_reset |=> st_q == host_pin_pkg::DMA_IDLE)
        else $error("abort ignored");
    lock_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        lock_s && master_reset_n_n_s && $past(lock_s) |=> $stable(ta_q))
        else $error("address changed under lock");
    read_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !rd_n_s && !cs_n_s |=> data_oe_o)
        else $error("read not answered");
    no_cs_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cs_n_s && !mem_busy ##1 !mem_busy |-> !data_oe_o)
        else $error("data driven without select");
    capture_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        in_reset |=> ta_q == $past(ta_s))
        else $error("address not captured");
    mem_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        granted_s ##2 strobe |-> !ram_select_out_n_o)
        else $error("memory not selected");
endmodule

/* File: host_ram_model.sv */
// Host side model: DMA grant source and external RAM strobe watcher
`timescale 1ns/10ps
module host_ram_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic dma_request_i,
    input wire logic ram_write_strobe_n_i,
    input wire logic ram_read_strobe_n_i,
    input wire logic addr_low_oe_i,
    input wire logic addr_high_oe_i,
    input wire logic addr_drive_permit_i,
    input wire logic [15:0] data_i,
    input wire logic [15:0] addr_i,
    input wire logic [3:0] grant_delay_i,
    output logic grant_n_o,
    output int writes_o,
    output int reads_o,
    output int faults_o,
    output logic [15:0] last_data_o,
    output logic [15:0] last_addr_o
);
    logic wr_q;
    logic rd_q;
    int wait_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Grant after a chosen delay so both prompt and slow hosts are seen
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            grant_n_o <= 1'b1;
            wait_q <= 0;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            writes_o <= 0;
            reads_o <= 0;
            faults_o <= 0;
            last_data_o <= 16'h0000;
            last_addr_o <= 16'h0000;
        end
        else
        begin
            wait_q <= dma_request_i ? wait_q + 1 : 0;
            grant_n_o <= !(dma_request_i && wait_q >= int'(grant_delay_i));
            wr_q <= ram_write_strobe_n_i;
            rd_q <= ram_read_strobe_n_i;
            if (wr_q && !ram_write_strobe_n_i)
            begin
                writes_o <= writes_o + 1;
                last_data_o <= data_i;
            end
            if (rd_q && !ram_read_strobe_n_i)
                reads_o <= reads_o + 1;
            if ((wr_q && !ram_write_strobe_n_i) || (rd_q && !ram_read_strobe_n_i))
                last_addr_o <= addr_i;
            if ((!ram_write_strobe_n_i || !ram_read_strobe_n_i) && grant_n_o)
                faults_o <= faults_o + 1;
            if ((addr_low_oe_i || addr_high_oe_i) && (grant_n_o || !addr_drive_permit_i))
                faults_o <= faults_o + 1;
        end
    end
endmodule

/* File: host_and_memory_pin_interface_bench.sv */
// Self-checking bench for the host and memory pin interface
`timescale 1ns/10ps
module host_and_memory_pin_interface_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic master_reset_n_n = 1'b0;
    logic rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1, permit = 1'b1, lock = 1'b0;
    logic pin = 1'b0, abort_n = 1'b1, msel_n = 1'b1, host_oe = 1'b0, tog = 1'b0;
    logic [3:0] host_a = 4'h0, gdly = 4'h0;
    logic [5:0] straps = 6'h00;
    logic [15:0] host_d = 16'h0000, data_o, addr_o, bus, rdv, last_d, last_a;
    logic data_oe, alo_oe, ahi_oe, msel_out_n, rrd_n, rwr_n, grant_n, req, role, pok;
    logic [4:0] ta_o;
    int errors = 0, check_count = 0, seed = 32'h8af2, writes, reads, faults, w0, r0;
    // Released data lines show a changing pattern, never the last value
    assign bus = data_oe ? data_o : (host_oe ? host_d : {8{tog, ~tog}});
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) tog <= ~tog;
    host_pin_if host_pin_if_i (
        .clk_sys_i(clk), .rst_i(rst), .master_reset_n_i(master_reset_n_n), .data_i(bus),
        .data_o(data_o), .data_oe_o(data_oe), .addr_low_i(alo_oe ? addr_o[3:0] : host_a),
        .addr_o(addr_o), .addr_low_oe_o(alo_oe), .addr_high_oe_o(ahi_oe), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .cs_n_i(cs_n), .addr_drive_permit_i(permit), .term_addr_i(straps),
        .role_select_pin_i(pin), .lock_i(lock), .external_abort_n_i(abort_n),
        .ram_select_in_n_i(msel_n), .ram_select_out_n_o(msel_out_n),
        .ram_read_strobe_n_o(rrd_n), .ram_write_strobe_n_o(rwr_n), .dma_grant_n_i(grant_n),
        .dma_request_o(req), .role_is_controller_o(role), .term_addr_o(ta_o),
        .term_addr_parity_ok_o(pok));
    host_ram_model host_ram_model_i (
        .clk_sys_i(clk), .rst_i(rst), .dma_request_i(req), .ram_write_strobe_n_i(rwr_n),
        .ram_read_strobe_n_i(rrd_n), .addr_low_oe_i(alo_oe), .addr_high_oe_i(ahi_oe),
        .addr_drive_permit_i(permit), .data_i(data_o), .addr_i(addr_o), .grant_delay_i(gdly),
        .grant_n_o(grant_n), .writes_o(writes), .reads_o(reads), .faults_o(faults),
        .last_data_o(last_d), .last_addr_o(last_a));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic odd_par(input logic [4:0] v);
        return ~^v;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobes held six cycles and gaps of at least six keep inside the synchroniser limits
    task automatic acc(input logic w, input logic c, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        cs_n <= ~c;
        rd_n <= w;
        wr_n <= ~w;
        host_a <= a;
        host_d <= d;
        host_oe <= w;
        repeat (5) @(posedge clk);
        #1 rdv = data_o;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        host_oe <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic mreset(input logic [5:0] s, input logic p);
        @(posedge clk);
        straps <= s;
        pin <= p;
        master_reset_n_n <= 1'b0;
        repeat (20) @(posedge clk);
        master_reset_n_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_done();
        for (int t = 0; t < 600 && req !== 1'b0; t++)
            @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 40000);
        errors++;
        print_verdict();
    end
    initial
    begin
        logic [4:0] ta;
        logic r;
        logic [15:0] d, a;
        int n;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            ta = 5'($random(seed));
            r = 1'($random(seed));
            mreset({odd_par(ta) ^ (i == 2), ta}, r);
            chk("term_addr", {11'h000, ta}, {11'h000, ta_o});
            acc(1'b0, 1'b1, 4'h2, 16'h0000);
            chk("term_addr_reg", {11'h000, ta}, {11'h000, rdv[4:0]});
            chk("parity_ok", {15'h0000, i != 2}, {15'h0000, pok});
        end
        for (int i = 0; i < 4; i++)
        begin
            r = 1'($random(seed));
            acc(1'b1, 1'b1, 4'h0, {15'h0000, r});
            chk("role", {15'h0000, r}, {15'h0000, role});
            acc(1'b1, 1'b0, 4'h0, {15'h0000, ~r});
            chk("role_no_cs", {15'h0000, r}, {15'h0000, role});
            acc(1'b0, 1'b1, 4'h0, 16'h0000);
            chk("ctl_reg", {15'h0000, r}, {15'h0000, rdv[0]});
        end
        lock <= 1'b1;
        mreset({odd_par(5'h0a), 5'h0a}, 1'b1);
        acc(1'b1, 1'b1, 4'h0, 16'h0000);
        acc(1'b1, 1'b1, 4'h2, 16'h0015);
        chk("role_locked", 16'h0001, {15'h0000, role});
        chk("term_locked", 16'h000a, {11'h000, ta_o});
        lock <= 1'b0;
        chk("idle_oe", 16'h0000, {13'h0000, data_oe, alo_oe, ahi_oe});
        acc(1'b1, 1'b1, 4'h0, 16'h0002);
        for (int i = 0; i < 2; i++)
        begin
            msel_n <= i[0];
            repeat (4) @(posedge clk);
            chk("ram_sel_pass", {15'h0000, i[0]}, {15'h0000, msel_out_n});
        end
        msel_n <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            n = 1 + ($random(seed) & 3);
            d = 16'($random(seed));
            gdly <= 4'($random(seed));
            a = 16'($random(seed));
            permit <= (k != 2);
            acc(1'b1, 1'b1, 4'h5, n[15:0]);
            acc(1'b1, 1'b1, 4'h3, a);
            acc(1'b1, 1'b1, 4'h4, d);
            w0 = writes;
            r0 = reads;
            acc(1'b1, 1'b1, 4'h0, {12'h000, k[0], 3'h4});
            wait_done();
            chk("write_pulses", 16'(k[0] ? n : 0), 16'(writes - w0));
            chk("read_pulses", 16'(k[0] ? 0 : n), 16'(reads - r0));
            chk("ram_addr", a + n[15:0] - 16'h0001, last_a);
            if (k[0])
                chk("ram_data", d, last_d);
        end
        chk("faults", 16'h0000, 16'(faults));
        acc(1'b1, 1'b1, 4'h5, 16'h000f);
        w0 = writes;
        acc(1'b1, 1'b1, 4'h0, 16'h000c);
        abort_n <= 1'b0;
        repeat (5) @(posedge clk);
        abort_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk("abort_req", 16'h0000, {15'h0000, req});
        // Long enough for an ignored abort to finish all fifteen words
        repeat (50) @(posedge clk);
        chk("abort_stops", 16'h0001, {15'h0000, (writes - w0) < 15});
        mreset(6'h20, 1'b0);
        acc(1'b0, 1'b1, 4'h0, 16'h0000);
        chk("ctl_after_reset", 16'h0000, rdv);
        print_verdict();
    end
endmodule
